/* core/sseq_pkg.sv */
package sseq_pkg;

    // ------------------------------------------------------------
    // Standard event bit positions
    // ------------------------------------------------------------
    localparam int unsigned SE_OPC_BIT   = 0;
    localparam int unsigned SE_QERR_BIT  = 2;
    localparam int unsigned SE_DERR_BIT  = 3;
    localparam int unsigned SE_EXE_BIT   = 4;
    localparam int unsigned SE_CMD_BIT   = 5;
    localparam int unsigned SE_PON_BIT   = 7;
    // Bits 1 and 6 never stored
    localparam logic [7:0]  SE_USED_MASK = 8'hbd;

    // ------------------------------------------------------------
    // Status byte bit positions
    // ------------------------------------------------------------
    localparam int unsigned SB_EAV_BIT   = 2;
    localparam int unsigned SB_QUES_BIT  = 3;
    localparam int unsigned SB_MAV_BIT   = 4;
    localparam int unsigned SB_ESB_BIT   = 5;
    localparam int unsigned SB_MSS_BIT   = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SE_RESET     = 8'h80;
    localparam logic [7:0]  ESE_RESET    = 8'h00;
    localparam logic [7:0]  SRE_RESET    = 8'h00;

    // ------------------------------------------------------------
    // Error queue
    // ------------------------------------------------------------
    localparam int unsigned EQ_DEPTH     = 10;
    localparam int unsigned EQ_AW        = 4;
    localparam int unsigned EQ_CW        = 16;
    localparam logic [15:0] EQ_NO_ERROR  = 16'h0000;
    localparam logic [15:0] EQ_OVERFLOW  = 16'hfebe;

    // ------------------------------------------------------------
    // Common command codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SSEQ_CMD_NONE = 4'h0,
        SSEQ_CMD_CLS  = 4'h1,
        SSEQ_CMD_ESE  = 4'h2,
        SSEQ_CMD_ESEQ = 4'h3,
        SSEQ_CMD_SRE  = 4'h4,
        SSEQ_CMD_SREQ = 4'h5,
        SSEQ_CMD_STBQ = 4'h6,
        SSEQ_CMD_ESRQ = 4'h7,
        SSEQ_CMD_OPC  = 4'h8,
        SSEQ_CMD_OPCQ = 4'h9,
        SSEQ_CMD_ERRQ = 4'ha,
        SSEQ_CMD_SYSC = 4'hb,
        SSEQ_CMD_RST  = 4'hc
    } sseq_cmd_e;

    // Pending operation-complete states
    typedef enum logic [1:0] {
        SSEQ_OPC_IDLE  = 2'b00,
        SSEQ_OPC_BIT   = 2'b01,
        SSEQ_OPC_QUERY = 2'b10
    } sseq_opc_e;

endpackage

/* core/sseq_err_queue.sv */
`timescale 1ns/10ps
module sseq_err_queue
    import sseq_pkg::*;
(
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    // Control
    input  wire logic                 i_clear,
    input  wire logic                 i_push,
    input  wire logic [EQ_CW-1:0]     i_code,
    input  wire logic                 i_pop,
    // Status
    output logic      [EQ_CW-1:0]     o_head,
    output logic                      o_empty
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [EQ_CW-1:0] mem_q [EQ_DEPTH];
    logic [EQ_AW-1:0] rd_q;
    logic [EQ_AW-1:0] cnt_q;
    logic             ovf_q;

    function automatic logic [EQ_AW-1:0] wrap(input logic [EQ_AW-1:0] p,
                                              input logic [EQ_AW-1:0] n);
        logic [EQ_AW:0] s;
        s = {1'b0, p} + {1'b0, n};
        if (s >= (EQ_AW+1)'(EQ_DEPTH)) begin
            s = s - (EQ_AW+1)'(EQ_DEPTH);
        end
        return s[EQ_AW-1:0];
    endfunction

    logic do_pop;
    logic do_push;
    logic acc_push;
    logic full;
    assign full    = (cnt_q == EQ_AW'(EQ_DEPTH));
    // A pop in the same cycle frees room for the push
    assign acc_push = do_push && (!full || do_pop);
    assign o_empty = (cnt_q == '0);
    assign do_pop  = i_pop && !o_empty;
    // Overflow locks out new entries until cleared
    assign do_push = i_push && !ovf_q;
    assign o_head  = o_empty ? EQ_NO_ERROR : mem_q[rd_q];

    // ------------------------------------------------------------
    // Pointers and count
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_q  <= '0;
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else if (i_clear) begin
            rd_q  <= '0;
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            if (do_pop) begin
                rd_q <= wrap(rd_q, EQ_AW'(1));
            end
            if (do_push && full && !do_pop) begin
                ovf_q <= 1'b1;
            end
            if (do_pop && !acc_push) begin
                cnt_q <= cnt_q - EQ_AW'(1);
            end else if (!do_pop && acc_push) begin
                cnt_q <= cnt_q + EQ_AW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Entry writes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_clear && do_push) begin
            if (full && !do_pop) begin
                // Newest slot becomes the overflow marker
                mem_q[wrap(rd_q, EQ_AW'(EQ_DEPTH-1))] <= EQ_OVERFLOW;
            end else begin
                mem_q[wrap(rd_q, cnt_q)] <= i_code;
            end
        end
    end

endmodule // sseq_err_queue

/* core/sseq_opc_tracker.sv */
`timescale 1ns/10ps
module sseq_opc_tracker
    import sseq_pkg::*;
(
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst_b,
    // Requests
    input  wire logic  i_arm_bit,
    input  wire logic  i_arm_query,
    input  wire logic  i_abort,
    input  wire logic  i_ops_busy,
    // Results
    output logic       o_set_bit,
    output logic       o_reply
);

    sseq_opc_e st_q;

    // Waits for idle; an arm while idle still takes one cycle
    assign o_set_bit = (st_q == SSEQ_OPC_BIT) && !i_ops_busy;
    assign o_reply   = (st_q == SSEQ_OPC_QUERY) && !i_ops_busy;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= SSEQ_OPC_IDLE;
        end else if (i_abort) begin
            st_q <= SSEQ_OPC_IDLE;
        end else begin
            unique case (st_q)
                SSEQ_OPC_IDLE: begin
                    if (i_arm_query) begin
                        st_q <= SSEQ_OPC_QUERY;
                    end else if (i_arm_bit) begin
                        st_q <= SSEQ_OPC_BIT;
                    end
                end
                SSEQ_OPC_BIT,
                SSEQ_OPC_QUERY: begin
                    if (!i_ops_busy) begin
                        st_q <= SSEQ_OPC_IDLE;
                    end
                end
                default: begin
                    st_q <= SSEQ_OPC_IDLE;
                end
            endcase
        end
    end

endmodule // sseq_opc_tracker

/* core/sseq_status.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - OPC bit set once operations finish
// - Bits 1 and 6 always zero
// - Query error events set bit 2
// - Device failures set bit 3
// - Execution error bit 4, syntax bit 5
// - Power-on bit set after reset
// - Enabled events raise event summary
// - Clear events on CLS or ESR read
// - ESE value replaces enable mask
// - ESE query returns mask unchanged
// - SRE value stored as request mask
// - SRE query returns stored mask
// - STB query keeps master summary
// - ESR query returns event register
// - CLS clears event registers and event summary
// - OPC query replies after operations finish
// - Error queue oldest first, removed on read
// - Overflow replaces last entry, locks queue
// - Empty queue read returns no error
// - Queue cleared by system clear or reset, not by RST command
// - Status bit 2 when queue nonempty
// - Status bit 5 is event summary
// - Status bit 6 is master summary
module sseq_status
    import sseq_pkg::*;
(
    // Clock and reset
    input  wire logic              I_REF_CLK,
    input  wire logic              I_RST_B,
    // Command from parser
    input  wire logic              I_CMD_VALID,
    input  wire logic [3:0]        I_CMD_CODE,
    input  wire logic [7:0]        I_CMD_ARG,
    // Event sources
    input  wire logic              I_EV_QUERY_ERR,
    input  wire logic              I_EV_DEVICE_ERR,
    input  wire logic              I_EV_EXEC_ERR,
    input  wire logic              I_EV_CMD_ERR,
    input  wire logic              I_BUF_FULL,
    input  wire logic              I_OPS_BUSY,
    // Error reports
    input  wire logic              I_ERR_PUSH,
    input  wire logic [EQ_CW-1:0]  I_ERR_CODE,
    // Other summaries
    input  wire logic              I_QUES_SUMMARY,
    input  wire logic              I_MSG_AVAIL,
    // Replies
    output logic                   O_RSP_VALID,
    output logic      [7:0]        O_RSP_BYTE,
    output logic                   O_ERR_VALID,
    output logic      [EQ_CW-1:0]  O_ERR_CODE,
    output logic                   O_OPC_REPLY,
    // Other groups
    output logic                   O_CLR_EVENTS,
    // Status
    output logic      [7:0]        O_STATUS_BYTE,
    output logic      [7:0]        O_EVENT_FLAGS
);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    function automatic logic is_cmd(input logic v,
                                    input logic [3:0] c,
                                    input sseq_cmd_e k);
        return v && (c == k);
    endfunction

    logic cmd_cls;
    logic cmd_ese;
    logic cmd_eseq;
    logic cmd_sre;
    logic cmd_sreq;
    logic cmd_stbq;
    logic cmd_esrq;
    logic cmd_opc;
    logic cmd_opcq;
    logic cmd_errq;
    logic cmd_sysc;
    logic cmd_any;

    assign cmd_cls  = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_CLS);
    assign cmd_ese  = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_ESE);
    assign cmd_eseq = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_ESEQ);
    assign cmd_sre  = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_SRE);
    assign cmd_sreq = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_SREQ);
    assign cmd_stbq = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_STBQ);
    assign cmd_esrq = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_ESRQ);
    assign cmd_opc  = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_OPC);
    assign cmd_opcq = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_OPCQ);
    assign cmd_errq = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_ERRQ);
    assign cmd_sysc = is_cmd(I_CMD_VALID, I_CMD_CODE, SSEQ_CMD_SYSC);
    assign cmd_any  = I_CMD_VALID;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]       sef_q;
    logic [7:0]       ese_q;
    logic [7:0]       sre_q;
    logic [7:0]       rsp_d;
    logic             opc_set;
    logic             eq_empty;
    logic [EQ_CW-1:0] eq_head;
    logic             esb;
    logic             mss;
    logic [7:0]       stb;
    logic [7:0]       set_vec;
    logic             qerr;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    sseq_err_queue u_queue (
        .i_clk   (I_REF_CLK),
        .i_rst_b (I_RST_B),
        .i_clear (cmd_sysc),
        .i_push  (I_ERR_PUSH),
        .i_code  (I_ERR_CODE),
        .i_pop   (cmd_errq),
        .o_head  (eq_head),
        .o_empty (eq_empty)
    );

    sseq_opc_tracker u_opc (
        .i_clk       (I_REF_CLK),
        .i_rst_b     (I_RST_B),
        .i_arm_bit   (cmd_opc),
        .i_arm_query (cmd_opcq),
        .i_abort     (1'b0),
        .i_ops_busy  (I_OPS_BUSY),
        .o_set_bit   (opc_set),
        .o_reply     (O_OPC_REPLY)
    );

    // ------------------------------------------------------------
    // Summaries
    // ------------------------------------------------------------
    assign esb = |(sef_q & ese_q);

    always_comb begin
        stb              = 8'h00;
        stb[SB_EAV_BIT]  = !eq_empty;
        stb[SB_QUES_BIT] = I_QUES_SUMMARY;
        stb[SB_MAV_BIT]  = I_MSG_AVAIL;
        stb[SB_ESB_BIT]  = esb;
    end
    // A status byte query never clears this bit
    assign mss = |(stb & sre_q & ~(8'h01 << SB_MSS_BIT));

    always_comb begin
        O_STATUS_BYTE             = stb;
        O_STATUS_BYTE[SB_MSS_BIT] = mss;
    end

    // ------------------------------------------------------------
    // Query error detection
    // ------------------------------------------------------------
    // Stale reads are flagged by the parser on I_EV_QUERY_ERR
    assign qerr = I_EV_QUERY_ERR || I_BUF_FULL ||
                  (cmd_errq && eq_empty);

    // ------------------------------------------------------------
    // Standard event register
    // ------------------------------------------------------------
    always_comb begin
        set_vec              = 8'h00;
        set_vec[SE_OPC_BIT]  = opc_set;
        set_vec[SE_QERR_BIT] = qerr;
        set_vec[SE_DERR_BIT] = I_EV_DEVICE_ERR;
        set_vec[SE_EXE_BIT]  = I_EV_EXEC_ERR;
        set_vec[SE_CMD_BIT]  = I_EV_CMD_ERR;
    end

    // Power-on bit comes from reset value; set wins over clear
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sef_q <= SE_RESET;
        end else if (cmd_cls || cmd_esrq) begin
            sef_q <= set_vec & SE_USED_MASK;
        end else begin
            sef_q <= (sef_q | set_vec) & SE_USED_MASK;
        end
    end
    assign O_EVENT_FLAGS = sef_q;
    assign O_CLR_EVENTS  = cmd_cls;

    // ------------------------------------------------------------
    // Enable masks
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ese_q <= ESE_RESET;
        end else if (cmd_ese) begin
            ese_q <= I_CMD_ARG;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sre_q <= SRE_RESET;
        end else if (cmd_sre) begin
            sre_q <= I_CMD_ARG;
        end
    end

    // ------------------------------------------------------------
    // Replies
    // ------------------------------------------------------------
    always_comb begin
        rsp_d = 8'h00;
        if (cmd_eseq) begin
            rsp_d = ese_q;
        end else if (cmd_sreq) begin
            rsp_d = sre_q;
        end else if (cmd_stbq) begin
            rsp_d = O_STATUS_BYTE;
        end else if (cmd_esrq) begin
            rsp_d = sef_q;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RSP_VALID <= 1'b0;
            O_RSP_BYTE  <= 8'h00;
        end else begin
            O_RSP_VALID <= cmd_eseq || cmd_sreq || cmd_stbq || cmd_esrq;
            O_RSP_BYTE  <= rsp_d;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_ERR_VALID <= 1'b0;
            O_ERR_CODE  <= EQ_NO_ERROR;
        end else begin
            O_ERR_VALID <= cmd_errq;
            if (cmd_errq) begin
                O_ERR_CODE <= eq_head;
            end
        end
    end

endmodule // sseq_status

/* dv/sseq_status_props.sv */
`timescale 1ns/10ps
module sseq_status_props
    import sseq_pkg::*;
(
    // Clock, reset, commands
    input wire logic       I_REF_CLK,
    input wire logic       I_RST_B,
    input wire logic       I_CMD_VALID,
    input wire logic [3:0] I_CMD_CODE,
    // Event sources
    input wire logic       I_EV_QUERY_ERR,
    input wire logic       I_EV_DEVICE_ERR,
    input wire logic       I_EV_EXEC_ERR,
    input wire logic       I_EV_CMD_ERR,
    input wire logic       I_BUF_FULL,
    input wire logic       I_OPS_BUSY,
    // Outputs watched
    input wire logic       O_RSP_VALID,
    input wire logic [7:0] O_RSP_BYTE,
    input wire logic       O_ERR_VALID,
    input wire logic       O_OPC_REPLY,
    input wire logic       O_CLR_EVENTS,
    input wire logic [7:0] O_STATUS_BYTE,
    input wire logic [7:0] O_EVENT_FLAGS
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);

    wire logic any_ev = I_EV_QUERY_ERR | I_EV_DEVICE_ERR | I_EV_EXEC_ERR
                      | I_EV_CMD_ERR | I_BUF_FULL;

    a_query_answer: assert property (I_CMD_VALID && (I_CMD_CODE inside
        {4'h3, 4'h5, 4'h6, 4'h7}) |=> O_RSP_VALID)
        else $error("query gave no answer");
    a_err_answer: assert property (I_CMD_VALID && I_CMD_CODE == 4'ha
        |=> O_ERR_VALID) else $error("error read gave no answer");
    a_stb_snapshot: assert property (I_CMD_VALID && I_CMD_CODE == 4'h6
        |=> O_RSP_BYTE == $past(O_STATUS_BYTE) && O_STATUS_BYTE[6] ==
        $past(O_STATUS_BYTE[6])) else $error("status query wrong");
    a_esr_return: assert property (I_CMD_VALID && I_CMD_CODE == 4'h7
        |=> O_RSP_BYTE == $past(O_EVENT_FLAGS))
        else $error("event query wrong");
    a_cls_clears: assert property (I_CMD_VALID && I_CMD_CODE == 4'h1
        && !any_ev |=> O_EVENT_FLAGS[7:1] == 7'h00)
        else $error("clear left events");
    a_cls_others: assert property (I_CMD_VALID && I_CMD_CODE == 4'h1
        |-> O_CLR_EVENTS) else $error("other groups not cleared");
    a_unused_zero: assert property (!O_EVENT_FLAGS[1] &&
        !O_EVENT_FLAGS[6]) else $error("unused event bit set");
    a_full_qerr: assert property (I_BUF_FULL |=> O_EVENT_FLAGS[2])
        else $error("full buffers missed");
    a_dev_err: assert property (I_EV_DEVICE_ERR |=> O_EVENT_FLAGS[3])
        else $error("device error missed");
    a_exec_err: assert property (I_EV_EXEC_ERR |=> O_EVENT_FLAGS[4])
        else $error("execution error missed");
    a_syntax_err: assert property (I_EV_CMD_ERR |=> O_EVENT_FLAGS[5])
        else $error("syntax error missed");
    a_opc_quiet: assert property (O_OPC_REPLY |-> !I_OPS_BUSY)
        else $error("reply while busy");
endmodule // sseq_status_props

bind sseq_status sseq_status_props u_props (
    .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_CMD_VALID(I_CMD_VALID),
    .I_CMD_CODE(I_CMD_CODE), .I_EV_QUERY_ERR(I_EV_QUERY_ERR),
    .I_EV_DEVICE_ERR(I_EV_DEVICE_ERR), .I_EV_EXEC_ERR(I_EV_EXEC_ERR),
    .I_EV_CMD_ERR(I_EV_CMD_ERR), .I_BUF_FULL(I_BUF_FULL),
    .I_OPS_BUSY(I_OPS_BUSY), .O_RSP_VALID(O_RSP_VALID),
    .O_RSP_BYTE(O_RSP_BYTE), .O_ERR_VALID(O_ERR_VALID),
    .O_OPC_REPLY(O_OPC_REPLY), .O_CLR_EVENTS(O_CLR_EVENTS),
    .O_STATUS_BYTE(O_STATUS_BYTE), .O_EVENT_FLAGS(O_EVENT_FLAGS)
);

/* dv/sseq_host.sv */
`timescale 1ns/10ps
module sseq_host
    import sseq_pkg::*;
(
    // Clock
    input  wire logic       i_clk,
    // Answers
    input  wire logic       i_rsp_valid,
    input  wire logic [7:0] i_rsp_byte,
    // Commands
    output logic            o_cmd_valid,
    output logic [3:0]      o_cmd_code,
    output logic [7:0]      o_cmd_arg
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_code  = 4'h0;
        o_cmd_arg   = 8'h00;
    end

    // One-cycle strobe; the argument is never left showing after it
    task automatic send(input sseq_cmd_e c, input logic [7:0] a);
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd_code  = c;
        o_cmd_arg   = a;
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd_code  = 4'h0;
        o_cmd_arg   = ~a;
    endtask

    // Answer stands only in the cycle after the take
    task automatic query(input sseq_cmd_e c, output logic v,
                         output logic [7:0] r);
        send(c, 8'h00);
        v = i_rsp_valid;
        r = i_rsp_byte;
    endtask
endmodule // sseq_host

/* dv/sseq_status_tb.sv */
`timescale 1ns/10ps
module sseq_status_tb
    import sseq_pkg::*;
;
    logic        clk, rst_b, buf_full, ops_busy, err_push, ques, msg;
    logic [3:0]  ev;
    logic [15:0] err_code, err_out;
    logic        cmd_valid, rsp_valid, err_valid, opc_reply;
    logic [3:0]  cmd_code;
    logic [7:0]  cmd_arg, rsp_byte, stb, flags;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n_reply = 0;

    sseq_status DUT (
        .I_REF_CLK(clk), .I_RST_B(rst_b), .I_CMD_VALID(cmd_valid),
        .I_CMD_CODE(cmd_code), .I_CMD_ARG(cmd_arg),
        .I_EV_QUERY_ERR(ev[0]), .I_EV_DEVICE_ERR(ev[1]),
        .I_EV_EXEC_ERR(ev[2]), .I_EV_CMD_ERR(ev[3]),
        .I_BUF_FULL(buf_full), .I_OPS_BUSY(ops_busy),
        .I_ERR_PUSH(err_push), .I_ERR_CODE(err_code),
        .I_QUES_SUMMARY(ques), .I_MSG_AVAIL(msg),
        .O_RSP_VALID(rsp_valid), .O_RSP_BYTE(rsp_byte),
        .O_ERR_VALID(err_valid), .O_ERR_CODE(err_out),
        .O_OPC_REPLY(opc_reply), .O_CLR_EVENTS(),
        .O_STATUS_BYTE(stb), .O_EVENT_FLAGS(flags)
    );

    sseq_host u_host (
        .i_clk(clk), .i_rsp_valid(rsp_valid), .i_rsp_byte(rsp_byte),
        .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
        .o_cmd_arg(cmd_arg)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic q(input sseq_cmd_e c, input logic [7:0] exp);
        logic       v;
        logic [7:0] r;
        u_host.query(c, v, r);
        check("reply", {7'h00, v, r}, {8'h01, exp});
    endtask

    task automatic pulse(input logic [3:0] e);
        tick(1);
        ev = e;
        tick(1);
        ev = 4'h0;
    endtask

    // Idle code is inverted so a stale value is never mistaken
    task automatic push(input logic [15:0] c);
        tick(1);
        err_push = 1'b1;
        err_code = c;
        tick(1);
        err_push = 1'b0;
        err_code = ~c;
    endtask

    task automatic read_err(input logic [15:0] exp);
        u_host.send(SSEQ_CMD_ERRQ, 8'h00);
        check("err_code", err_out, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_on();
        q(SSEQ_CMD_ESRQ, 8'h80);
        q(SSEQ_CMD_ESRQ, 8'h00);
        q(SSEQ_CMD_ESEQ, 8'h00);
        q(SSEQ_CMD_SREQ, 8'h00);
    endtask

    task automatic t_events();
        for (int i = 0; i < 4; i++) begin
            pulse(4'h1 << i);
            q(SSEQ_CMD_ESRQ, 8'h04 << i);
        end
        buf_full = 1'b1;
        tick(3);
        buf_full = 1'b0;
        q(SSEQ_CMD_ESRQ, 8'h04);
    endtask

    task automatic t_masks();
        u_host.send(SSEQ_CMD_ESE, 8'h41);
        q(SSEQ_CMD_ESEQ, 8'h41);
        q(SSEQ_CMD_ESEQ, 8'h41);
        u_host.send(SSEQ_CMD_SRE, 8'h20);
        q(SSEQ_CMD_SREQ, 8'h20);
        pulse(4'h8);
        check("stb", 16'(stb), 16'h0000);
        u_host.send(SSEQ_CMD_ESE, 8'h20);
        check("stb", 16'(stb), 16'h0060);
        q(SSEQ_CMD_STBQ, 8'h60);
        check("stb", 16'(stb), 16'h0060);
        ques = 1'b1;
        msg = 1'b1;
        u_host.send(SSEQ_CMD_SRE, 8'h00);
        check("stb", 16'(stb), 16'h0038);
        ques = 1'b0;
        msg = 1'b0;
        u_host.send(SSEQ_CMD_CLS, 8'h00);
        check("flags", 16'(flags), 16'h0000);
        check("stb", 16'(stb), 16'h0000);
    endtask

    task automatic t_opc();
        ops_busy = 1'b1;
        u_host.send(SSEQ_CMD_OPC, 8'h00);
        tick(4);
        check("opc_bit", 16'(flags[0]), 16'h0000);
        ops_busy = 1'b0;
        tick(2);
        check("opc_bit", 16'(flags[0]), 16'h0001);
        q(SSEQ_CMD_ESRQ, 8'h01);
        ops_busy = 1'b1;
        u_host.send(SSEQ_CMD_OPCQ, 8'h00);
        tick(4);
        check("replies", 16'(n_reply), 16'h0000);
        ops_busy = 1'b0;
        tick(3);
        check("replies", 16'(n_reply), 16'h0001);
    endtask

    task automatic t_queue();
        for (int i = 1; i <= 3; i++) push(16'h0100 + 16'(i));
        check("eav", 16'(stb[2]), 16'h0001);
        for (int i = 1; i <= 3; i++) read_err(16'h0100 + 16'(i));
        check("eav", 16'(stb[2]), 16'h0000);
        read_err(EQ_NO_ERROR);
        q(SSEQ_CMD_ESRQ, 8'h04);
        // Twelve pushes: the eleventh overflows, the twelfth is dropped
        for (int i = 1; i <= 12; i++) push(16'h0200 + 16'(i));
        for (int i = 1; i <= 9; i++) read_err(16'h0200 + 16'(i));
        read_err(EQ_OVERFLOW);
        push(16'h0300);
        read_err(EQ_NO_ERROR);
        u_host.send(SSEQ_CMD_SYSC, 8'h00);
        push(16'h0302);
        u_host.send(SSEQ_CMD_RST, 8'h00);
        read_err(16'h0302);
        push(16'h0303);
        u_host.send(SSEQ_CMD_SYSC, 8'h00);
        read_err(EQ_NO_ERROR);
    endtask

    // Reset in mid-run: power-on bit back, queue and event enable mask emptied
    task automatic t_reset();
        u_host.send(SSEQ_CMD_ESE, 8'h10);
        push(16'h0400);
        tick(1);
        rst_b = 1'b0;
        tick(2);
        check("flags", 16'(flags), 16'h0080);
        check("eav", 16'(stb[2]), 16'h0000);
        rst_b = 1'b1;
        q(SSEQ_CMD_ESEQ, 8'h00);
        q(SSEQ_CMD_ESRQ, 8'h80);
        read_err(EQ_NO_ERROR);
    endtask

    // ------------------------------------------------------------
    // Clock, monitor, timeout, main
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (opc_reply === 1'b1) n_reply++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        rst_b = 1'b0;
        ev = 4'h0;
        buf_full = 1'b0;
        ops_busy = 1'b0;
        err_push = 1'b0;
        err_code = 16'h0000;
        ques = 1'b0;
        msg = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_power_on();
        t_events();
        t_masks();
        t_opc();
        t_queue();
        t_reset();
        stop_test();
    end
endmodule // sseq_status_tb
